// *** design/tlic_pkg.sv ***
// Purpose: Constants shared by the three level interrupt controller
// Assumes: Eight bit special function register space of the core
// Notes:   Source index order is the fixed polling order, index 0 polled first
`default_nettype none
package tlic_pkg;

   localparam int          NUM_SRC          = 12;

   // Byte addresses of the registers
   localparam logic [7:0]  ADDR_IE_MAIN     = 8'hA8;
   localparam logic [7:0]  ADDR_IEIP_SECOND = 8'hA9;
   localparam logic [7:0]  ADDR_IP_MAIN     = 8'hB8;
   localparam logic [7:0]  ADDR_WDOG_CTRL   = 8'hC0;

   // Values after reset
   localparam logic [7:0]  RST_IE_MAIN      = 8'h00;
   localparam logic [7:0]  RST_IEIP_SECOND  = 8'hA0;
   localparam logic [7:0]  RST_IP_MAIN      = 8'h00;
   localparam logic [7:0]  RST_WDOG_CTRL    = 8'h10;
   // Reserved bits of the second register, fixed at their reset value
   localparam logic [7:0]  IEIP_RSVD_MASK   = 8'hA0;

   // Field positions
   localparam int          GLOBAL_EN_BIT    = 7;
   localparam int          TEMP_EN_BIT      = 6;
   localparam int          T2_EN_BIT        = 5;
   localparam int          UART_EN_BIT      = 4;
   localparam int          T1_EN_BIT        = 3;
   localparam int          EXT1_EN_BIT      = 2;
   localparam int          T0_EN_BIT        = 1;
   localparam int          EXT0_EN_BIT      = 0;
   localparam int          DSP_PRI_BIT      = 7;
   localparam int          TEMP_PRI_BIT     = 6;
   localparam int          T2_PRI_BIT       = 5;
   localparam int          UART_PRI_BIT     = 4;
   localparam int          T1_PRI_BIT       = 3;
   localparam int          EXT1_PRI_BIT     = 2;
   localparam int          T0_PRI_BIT       = 1;
   localparam int          EXT0_PRI_BIT     = 0;
   localparam int          RTC_PRI_BIT      = 6;
   localparam int          SERIAL_PRI_BIT   = 4;
   localparam int          DSP_EN_BIT       = 3;
   localparam int          RTC_EN_BIT       = 2;
   localparam int          SUPPLY_EN_BIT    = 1;
   localparam int          SERIAL_EN_BIT    = 0;

   // Priority levels
   localparam logic [1:0]  LVL_LOW          = 2'h0;
   localparam logic [1:0]  LVL_HIGH         = 2'h1;
   localparam logic [1:0]  LVL_TOP          = 2'h2;

   // Vectors in polling order: supply, rtc, dsp, watchdog, temp, ext0,
   // timer0, ext1, timer1, serial, uart, timer2
   localparam logic [NUM_SRC*16-1:0] VECTOR_TABLE = {
      16'h002B, 16'h0023, 16'h003B, 16'h001B, 16'h0013, 16'h000B,
      16'h0003, 16'h0033, 16'h005B, 16'h004B, 16'h0053, 16'h0043};

   localparam logic [15:0] RST_VECTOR       = 16'h0000;

   typedef struct packed {
      logic [7:0]  ie_main;
      logic [7:0]  ip_main;
      logic [7:0]  ieip_second;
      logic [7:0]  wdog_ctrl;
      logic [2:0]  in_service;
      logic        hold;
      logic        req;
      logic [15:0] vector;
      logic [3:0]  source;
      logic [1:0]  level;
      logic [7:0]  rdata;
      logic        bit_rdata;
   } tlic_state_type;

endpackage

`default_nettype wire

// *** design/tlic_controller.sv ***
// Purpose: Three level interrupt controller for the microcontroller core
// Assumes: Requests and core strobes come from logic on core_clk
// Notes:   Register reads answer one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Twelve request sources arbitrated over three priority levels.
// - Supply request alone at top level, preempts any high or low level routine.
// - High level request preempts a low level routine.
// - Simultaneous requests of different level: higher level vectored first.
// - Same level never preempts; request waits for the return.
// - Equal level ties resolved by fixed polling order, supply first.
// - Global enable bit 7 clear blocks all vectoring.
// - Main enable register gates seven sources, one bit each.
// - Main priority register bit one means high, zero low.
// - Second register holds rtc, serial priorities and four enables.
// - Reset clears enable and priority, second register loads its default.
// - Main enable and priority bit addressable; second register byte only.
// - Interrupts are only taken while the core is active.
// - Each source vectors to its fixed address, eight bytes apart.
// - After return or enable or priority register access, one instruction completes first.
module tlic_controller (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        supply_mgmt_request,
   input  wire logic        rtc_request,
   input  wire logic        energy_dsp_request,
   input  wire logic        watchdog_request,
   input  wire logic        temp_adc_request,
   input  wire logic        ext0_request,
   input  wire logic        timer0_request,
   input  wire logic        ext1_request,
   input  wire logic        timer1_request,
   input  wire logic        serial_if_request,
   input  wire logic        uart_request,
   input  wire logic        timer2_request,
   input  wire logic        core_active,
   input  wire logic        instr_done,
   input  wire logic        return_from_interrupt,
   input  wire logic        irq_ack,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic [7:0]  bit_addr,
   input  wire logic        bit_wr,
   input  wire logic        bit_rd,
   input  wire logic        bit_wdata,
   output logic             irq_req,
   output logic [15:0]      irq_vector,
   output logic [3:0]       irq_source,
   output logic [1:0]       irq_level,
   output logic [2:0]       in_service,
   output logic [7:0]       sfr_rdata,
   output logic             bit_rdata
);

   tlic_pkg::tlic_state_type s_r;
   tlic_pkg::tlic_state_type s_nxt;

   logic [tlic_pkg::NUM_SRC-1:0] src_req;
   logic [tlic_pkg::NUM_SRC-1:0] src_en;
   logic [tlic_pkg::NUM_SRC-1:0] src_high;
   logic [tlic_pkg::NUM_SRC-1:0] src_act;
   logic [1:0]                   src_lvl [tlic_pkg::NUM_SRC];
   logic [7:0]                   bit_byte;

   // Request lines in polling order
   // Index zero is polled first and carries the supply request
   assign src_req = {timer2_request, uart_request, serial_if_request,
                     timer1_request, ext1_request, timer0_request,
                     ext0_request, temp_adc_request, watchdog_request,
                     energy_dsp_request, rtc_request, supply_mgmt_request};

   // Per source enables
   // Watchdog has no enable bit, only the global bit gates it
   assign src_en = {s_r.ie_main[tlic_pkg::T2_EN_BIT],
                    s_r.ie_main[tlic_pkg::UART_EN_BIT],
                    s_r.ieip_second[tlic_pkg::SERIAL_EN_BIT],
                    s_r.ie_main[tlic_pkg::T1_EN_BIT],
                    s_r.ie_main[tlic_pkg::EXT1_EN_BIT],
                    s_r.ie_main[tlic_pkg::T0_EN_BIT],
                    s_r.ie_main[tlic_pkg::EXT0_EN_BIT],
                    s_r.ie_main[tlic_pkg::TEMP_EN_BIT],
                    1'b1,
                    s_r.ieip_second[tlic_pkg::DSP_EN_BIT],
                    s_r.ieip_second[tlic_pkg::RTC_EN_BIT],
                    s_r.ieip_second[tlic_pkg::SUPPLY_EN_BIT]};

   // Per source priority selection, watchdog fixed high
   assign src_high = {s_r.ip_main[tlic_pkg::T2_PRI_BIT],
                      s_r.ip_main[tlic_pkg::UART_PRI_BIT],
                      s_r.ieip_second[tlic_pkg::SERIAL_PRI_BIT],
                      s_r.ip_main[tlic_pkg::T1_PRI_BIT],
                      s_r.ip_main[tlic_pkg::EXT1_PRI_BIT],
                      s_r.ip_main[tlic_pkg::T0_PRI_BIT],
                      s_r.ip_main[tlic_pkg::EXT0_PRI_BIT],
                      s_r.ip_main[tlic_pkg::TEMP_PRI_BIT],
                      1'b1,
                      s_r.ip_main[tlic_pkg::DSP_PRI_BIT],
                      s_r.ieip_second[tlic_pkg::RTC_PRI_BIT],
                      1'b0};

   // Level and activity of each source
   // Supply source is wired to the top level, others pick high or low
   genvar gi;
   generate
      for (gi = 0; gi < tlic_pkg::NUM_SRC; gi++) begin : g_src
         if (gi == 0) begin : g_top
            assign src_lvl[gi] = tlic_pkg::LVL_TOP;
         end else begin : g_cfg
            assign src_lvl[gi] = src_high[gi] ? tlic_pkg::LVL_HIGH
                                              : tlic_pkg::LVL_LOW;
         end
         assign src_act[gi] = src_req[gi] & src_en[gi]
                              & s_r.ie_main[tlic_pkg::GLOBAL_EN_BIT];
      end
   endgenerate

   // Byte that holds the addressed bit
   // The second register has no bit addresses, so it never shows here
   always_comb begin
      bit_byte = 8'h00;
      if (bit_addr[7:3] == tlic_pkg::ADDR_IE_MAIN[7:3]) begin
         bit_byte = s_r.ie_main;
      end else if (bit_addr[7:3] == tlic_pkg::ADDR_IP_MAIN[7:3]) begin
         bit_byte = s_r.ip_main;
      end else if (bit_addr[7:3] == tlic_pkg::ADDR_WDOG_CTRL[7:3]) begin
         bit_byte = s_r.wdog_ctrl;
      end
   end

   always_comb begin
      logic                reg_touch;
      logic                found;
      logic [3:0]          best_idx;
      logic [1:0]          best_lvl;
      logic [1:0]          cur_lvl;
      logic                busy;
      logic [7:0]          wbyte;

      reg_touch = 1'b0;
      found     = 1'b0;
      best_idx  = 4'h0;
      best_lvl  = tlic_pkg::LVL_LOW;
      cur_lvl   = tlic_pkg::LVL_LOW;
      busy      = 1'b0;
      wbyte     = bit_byte;
      s_nxt     = s_r;

      // Byte writes; second register is byte only
      // Reserved bits of the second register are forced so they read as one
      if (sfr_wr) begin
         if (sfr_addr == tlic_pkg::ADDR_IE_MAIN) begin
            s_nxt.ie_main = sfr_wdata;
         end else if (sfr_addr == tlic_pkg::ADDR_IP_MAIN) begin
            s_nxt.ip_main = sfr_wdata;
         end else if (sfr_addr == tlic_pkg::ADDR_IEIP_SECOND) begin
            s_nxt.ieip_second = (sfr_wdata & ~tlic_pkg::IEIP_RSVD_MASK)
                                | tlic_pkg::IEIP_RSVD_MASK;
         end else if (sfr_addr == tlic_pkg::ADDR_WDOG_CTRL) begin
            s_nxt.wdog_ctrl = sfr_wdata;
         end
      end

      // Single bit writes to bit addressable registers
      // The bit is merged into the current byte before the write
      if (bit_wr) begin
         wbyte[bit_addr[2:0]] = bit_wdata;
         if (bit_addr[7:3] == tlic_pkg::ADDR_IE_MAIN[7:3]) begin
            s_nxt.ie_main = wbyte;
         end else if (bit_addr[7:3] == tlic_pkg::ADDR_IP_MAIN[7:3]) begin
            s_nxt.ip_main = wbyte;
         end else if (bit_addr[7:3] == tlic_pkg::ADDR_WDOG_CTRL[7:3]) begin
            s_nxt.wdog_ctrl = wbyte;
         end
      end

      // Byte reads, registered
      if (sfr_rd) begin
         if (sfr_addr == tlic_pkg::ADDR_IE_MAIN) begin
            s_nxt.rdata = s_r.ie_main;
         end else if (sfr_addr == tlic_pkg::ADDR_IP_MAIN) begin
            s_nxt.rdata = s_r.ip_main;
         end else if (sfr_addr == tlic_pkg::ADDR_IEIP_SECOND) begin
            s_nxt.rdata = s_r.ieip_second;
         end else if (sfr_addr == tlic_pkg::ADDR_WDOG_CTRL) begin
            s_nxt.rdata = s_r.wdog_ctrl;
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end

      // Bit reads, registered
      // Unmapped bit addresses read zero
      if (bit_rd) begin
         s_nxt.bit_rdata = bit_byte[bit_addr[2:0]];
      end

      // Access to enable or priority registers
      // Reads hold off vectoring as well as writes; never too early
      if ((sfr_wr || sfr_rd) && (sfr_addr == tlic_pkg::ADDR_IE_MAIN
                                 || sfr_addr == tlic_pkg::ADDR_IP_MAIN
                                 || sfr_addr == tlic_pkg::ADDR_IEIP_SECOND)) begin
         reg_touch = 1'b1;
      end
      if ((bit_wr || bit_rd) && (bit_addr[7:3] == tlic_pkg::ADDR_IE_MAIN[7:3]
                                 || bit_addr[7:3] == tlic_pkg::ADDR_IP_MAIN[7:3])) begin
         reg_touch = 1'b1;
      end

      // Hold off vectoring until one more instruction completes
      // The setting event wins over an instruction ending in the same cycle
      if (return_from_interrupt || reg_touch) begin
         s_nxt.hold = 1'b1;
      end else if (instr_done) begin
         s_nxt.hold = 1'b0;
      end

      // Return releases the highest level in service
      // Applied before acceptance, so a same cycle accept keeps its level
      if (return_from_interrupt) begin
         if (s_r.in_service[tlic_pkg::LVL_TOP]) begin
            s_nxt.in_service[tlic_pkg::LVL_TOP] = 1'b0;
         end else if (s_r.in_service[tlic_pkg::LVL_HIGH]) begin
            s_nxt.in_service[tlic_pkg::LVL_HIGH] = 1'b0;
         end else begin
            s_nxt.in_service[tlic_pkg::LVL_LOW] = 1'b0;
         end
      end

      // Acceptance marks the vectored level in service
      // An acknowledge with no offer standing is ignored
      if (irq_ack && s_r.req) begin
         s_nxt.in_service[s_r.level] = 1'b1;
      end

      // Highest level first, then polling order
      // Scan runs downward so the lowest index wins among equal levels
      for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (src_act[i] && (!found || src_lvl[i] >= best_lvl)) begin
            found    = 1'b1;
            best_idx = 4'(i);
            best_lvl = src_lvl[i];
         end
      end

      // Level of the routine now running
      // Next state is used so an accepted source is not offered twice
      if (s_nxt.in_service[tlic_pkg::LVL_TOP]) begin
         cur_lvl = tlic_pkg::LVL_TOP;
         busy    = 1'b1;
      end else if (s_nxt.in_service[tlic_pkg::LVL_HIGH]) begin
         cur_lvl = tlic_pkg::LVL_HIGH;
         busy    = 1'b1;
      end else if (s_nxt.in_service[tlic_pkg::LVL_LOW]) begin
         cur_lvl = tlic_pkg::LVL_LOW;
         busy    = 1'b1;
      end

      // Only a strictly higher level preempts
      // Vector, source and level keep their last value while no offer stands
      s_nxt.req = found && (!busy || best_lvl > cur_lvl)
                  && core_active
                  && !s_nxt.hold;
      if (s_nxt.req) begin
         s_nxt.source = best_idx;
         s_nxt.level  = best_lvl;
         s_nxt.vector = tlic_pkg::VECTOR_TABLE[best_idx*16 +: 16];
      end
   end

   // Asynchronous reset loads constants only
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r.ie_main     <= tlic_pkg::RST_IE_MAIN;
         s_r.ip_main     <= tlic_pkg::RST_IP_MAIN;
         s_r.ieip_second <= tlic_pkg::RST_IEIP_SECOND;
         s_r.wdog_ctrl   <= tlic_pkg::RST_WDOG_CTRL;
         s_r.in_service  <= 3'h0;
         s_r.hold        <= 1'b0;
         s_r.req         <= 1'b0;
         s_r.vector      <= tlic_pkg::RST_VECTOR;
         s_r.source      <= 4'h0;
         s_r.level       <= tlic_pkg::LVL_LOW;
         s_r.rdata       <= 8'h00;
         s_r.bit_rdata   <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // All outputs come straight from the state register
   assign irq_req    = s_r.req;
   assign irq_vector = s_r.vector;
   assign irq_source = s_r.source;
   assign irq_level  = s_r.level;
   assign in_service = s_r.in_service;
   assign sfr_rdata  = s_r.rdata;
   assign bit_rdata  = s_r.bit_rdata;

endmodule

`default_nettype wire

// *** bench/tlic_core_model.sv ***
// Purpose: Core sequencer model, takes offered vectors and issues returns
// Assumes: Same clock as the controller
// Notes:   Ack delay and return timing set by the bench
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       irq_req,
   input  wire logic [1:0] ack_wait,
   input  wire logic       ret_cmd,
   output logic            instr_done,
   output logic            irq_ack,
   output logic            ret_pulse
);
   logic       ret_pend_r;
   logic [1:0] cnt_r;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_done <= 1'b0;
         irq_ack    <= 1'b0;
         ret_pulse  <= 1'b0;
         ret_pend_r <= 1'b0;
         cnt_r      <= 2'h0;
      end else begin
         instr_done <= !instr_done;
         ret_pulse  <= ret_pend_r && !instr_done;
         ret_pend_r <= ret_cmd || (ret_pend_r && instr_done);
         irq_ack    <= irq_req && !irq_ack && cnt_r >= ack_wait;
         cnt_r      <= (irq_req && !irq_ack) ? cnt_r + 2'h1 : 2'h0;
      end
   end
endmodule
`default_nettype wire

// *** bench/tlic_props.sv ***
// Purpose: Port assertions for the interrupt controller
// Assumes: One clock, reset_n active low
// Notes:   Bound to the controller below
`timescale 1ns/1ps
`default_nettype none
module tlic_props (
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic        core_active,
   input wire logic        return_from_interrupt,
   input wire logic        irq_ack,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_rd,
   input wire logic        irq_req,
   input wire logic [15:0] irq_vector,
   input wire logic [3:0]  irq_source,
   input wire logic [1:0]  irq_level,
   input wire logic [2:0]  in_service,
   input wire logic [7:0]  sfr_rdata
);
   logic [2:0] keep_mask;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   assign keep_mask = in_service[2] ? 3'h3 : (in_service[1] ? 3'h1 : 3'h0);
   sequence s_take; irq_req && irq_ack && !return_from_interrupt; endsequence
   sequence s_ret; return_from_interrupt && !irq_ack; endsequence
   property p_idle; !core_active |=> !irq_req; endproperty
   a_idle: assert property (p_idle) else $error("offer while core idle");
   property p_gap; return_from_interrupt |=> !irq_req; endproperty
   a_gap: assert property (p_gap) else $error("offer right after return");
   property p_take; s_take |=> in_service[$past(irq_level)]; endproperty
   a_take: assert property (p_take) else $error("level not marked in service");
   property p_ret; s_ret |=> in_service == ($past(in_service) & $past(keep_mask)); endproperty
   a_ret: assert property (p_ret) else $error("return released wrong level");
   property p_rank; irq_req |-> (in_service >> irq_level) == 3'h0; endproperty
   a_rank: assert property (p_rank) else $error("offer not above running level");
   property p_vec; irq_req |-> irq_vector == tlic_pkg::VECTOR_TABLE[irq_source*16 +: 16]; endproperty
   a_vec: assert property (p_vec) else $error("vector does not match source");
   property p_top; irq_req |-> (irq_source == 4'h0) == (irq_level == tlic_pkg::LVL_TOP); endproperty
   a_top: assert property (p_top) else $error("top level misuse");
   property p_wdog; irq_req && irq_source == 4'h3 |-> irq_level == tlic_pkg::LVL_HIGH; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog level wrong");
   property p_rsvd; sfr_rd && sfr_addr == tlic_pkg::ADDR_IEIP_SECOND |=> sfr_rdata[7] && sfr_rdata[5];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not set");
endmodule
bind tlic_controller tlic_props u_props (
   .core_clk(core_clk), .reset_n(reset_n), .core_active(core_active),
   .return_from_interrupt(return_from_interrupt), .irq_ack(irq_ack), .sfr_addr(sfr_addr),
   .sfr_rd(sfr_rd), .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
   .irq_level(irq_level), .in_service(in_service), .sfr_rdata(sfr_rdata)
);
`default_nettype wire

// *** bench/tb_three_level_interrupt_controller.sv ***
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model takes offers and returns on command
// Notes:   Driver queues expected vectors and read data, monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb_three_level_interrupt_controller;
   localparam logic [15:0] VEC [12] = '{16'h0043, 16'h0053, 16'h004b, 16'h005b, 16'h0033,
      16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b};
   logic        core_clk = 1'b0, reset_n = 1'b0, core_active = 1'b1, rd_d = 1'b0;
   logic        sfr_wr = 1'b0, sfr_rd = 1'b0, bit_wr = 1'b0, bit_wdata = 1'b0, ret_cmd = 1'b0;
   logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, sfr_rdata;
   logic        bit_rd = 1'b0, brd_d = 1'b0;
   logic [11:0] req_r = 12'h000;
   logic [1:0]  ack_wait = 2'h0, irq_level;
   logic        instr_done, irq_ack, ret_pulse, irq_req, bit_rdata;
   logic [15:0] irq_vector;
   logic [3:0]  irq_source;
   logic [2:0]  in_service;
   logic [15:0] exp_vec[$];
   logic [7:0]  exp_rd[$];
   logic        exp_bit[$];
   int          bad_count = 0, num_checks = 0, ack_cnt = 0, seed = 32'h30bc_57b4;
   always #50 core_clk = ~core_clk;
   tlic_controller uut (.core_clk(core_clk), .reset_n(reset_n),
      .supply_mgmt_request(req_r[0]), .rtc_request(req_r[1]), .energy_dsp_request(req_r[2]),
      .watchdog_request(req_r[3]), .temp_adc_request(req_r[4]), .ext0_request(req_r[5]),
      .timer0_request(req_r[6]), .ext1_request(req_r[7]), .timer1_request(req_r[8]),
      .serial_if_request(req_r[9]), .uart_request(req_r[10]), .timer2_request(req_r[11]),
      .core_active(core_active), .instr_done(instr_done), .return_from_interrupt(ret_pulse),
      .irq_ack(irq_ack), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_rd(bit_rd),
      .bit_wdata(bit_wdata), .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
      .irq_level(irq_level), .in_service(in_service), .sfr_rdata(sfr_rdata),
      .bit_rdata(bit_rdata));
   tlic_core_model core (.core_clk(core_clk), .reset_n(reset_n), .irq_req(irq_req),
      .ack_wait(ack_wait), .ret_cmd(ret_cmd), .instr_done(instr_done), .irq_ack(irq_ack),
      .ret_pulse(ret_pulse));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      if (rd) exp_rd.push_back(d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_rd <= rd;
      sfr_wr <= !rd;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b0;
   endtask
   task automatic bit_acc(input logic rd, input logic [7:0] a, input logic d);
      @(posedge core_clk);
      if (rd) exp_bit.push_back(d);
      bit_addr <= a;
      bit_wdata <= d;
      bit_rd <= rd;
      bit_wr <= !rd;
      @(posedge core_clk);
      bit_rd <= 1'b0;
      bit_wr <= 1'b0;
   endtask
   task automatic bset(input logic [7:0] a);
      bit_acc(1'b0, a, 1'b1);
   endtask
   task automatic wait_ack(input int n);
      for (int i = 0; i < 200 && ack_cnt < n; i++) @(posedge core_clk);
      if (ack_cnt < n) begin
         bad_count++;
         $display("[FAIL] %0t no vector taken", $time);
         close_out();
      end
   endtask
   task automatic ret();
      @(posedge core_clk);
      ret_cmd <= 1'b1;
      @(posedge core_clk);
      ret_cmd <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   // Monitor: compares each taken vector and each read result
   always @(posedge core_clk) begin
      if (reset_n && irq_req === 1'b1 && irq_ack === 1'b1) begin
         ack_cnt++;
         req_r[irq_source] <= 1'b0;
         if (exp_vec.size() == 0) chk(irq_vector, 16'hffff);
         else chk(irq_vector, exp_vec.pop_front());
      end
      if (rd_d) chk({8'h00, sfr_rdata}, {8'h00, exp_rd.pop_front()});
      rd_d <= sfr_rd;
      if (brd_d) chk({15'h0000, bit_rdata}, {15'h0000, exp_bit.pop_front()});
      brd_d <= bit_rd;
   end
   initial begin
      logic [31:0] tmp;
      logic [11:0] hi;
      int          base;
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      acc(1'b1, 8'ha8, 8'h00);
      acc(1'b1, 8'hb8, 8'h00);
      acc(1'b1, 8'ha9, 8'ha0);
      acc(1'b1, 8'hc0, 8'h10);
      acc(1'b1, 8'h55, 8'h00);
      acc(1'b0, 8'ha9, 8'h00);
      acc(1'b1, 8'ha9, 8'ha0);
      bset(8'haf);
      bset(8'hb9);
      bit_acc(1'b1, 8'haf, 1'b1);
      bit_acc(1'b1, 8'hc4, 1'b1);
      bit_acc(1'b0, 8'hb9, 1'b0);
      bit_acc(1'b1, 8'hb9, 1'b0);
      bit_acc(1'b0, 8'hb9, 1'b1);
      acc(1'b1, 8'ha8, 8'h80);
      acc(1'b1, 8'hb8, 8'h02);
      $display("test registers done");
      acc(1'b0, 8'ha8, 8'h01);
      req_r[5] <= 1'b1;
      repeat (8) @(posedge core_clk);
      core_active <= 1'b0;
      bset(8'haf);
      repeat (8) @(posedge core_clk);
      exp_vec.push_back(16'h0003);
      core_active <= 1'b1;
      wait_ack(1);
      ret();
      $display("test gating done");
      acc(1'b0, 8'ha8, 8'h87);
      acc(1'b0, 8'ha9, 8'h02);
      exp_vec = '{16'h0003, 16'h000b, 16'h0043, 16'h0013};
      req_r[5] <= 1'b1;
      wait_ack(2);
      req_r[7] <= 1'b1;
      repeat (6) @(posedge core_clk);
      req_r[6] <= 1'b1;
      wait_ack(3);
      req_r[0] <= 1'b1;
      wait_ack(4);
      repeat (3) ret();
      wait_ack(5);
      ret();
      $display("test preemption done");
      for (int r = 0; r < 2; r++) begin
         tmp = $random(seed);
         ack_wait <= tmp[17:16];
         acc(1'b0, 8'hb8, tmp[7:0]);
         acc(1'b0, 8'ha9, (tmp[15:8] & 8'h50) | 8'h0f);
         acc(1'b0, 8'ha8, 8'hff);
         hi = {tmp[5], tmp[4], tmp[12], tmp[3:0], tmp[6], 1'b1, tmp[7], tmp[14], 1'b0};
         exp_vec.push_back(16'h0043);
         for (int k = 1; k < 12; k++) if (hi[k]) exp_vec.push_back(VEC[k]);
         for (int k = 1; k < 12; k++) if (!hi[k]) exp_vec.push_back(VEC[k]);
         base = ack_cnt;
         req_r <= 12'hfff;
         for (int k = 1; k <= 12; k++) begin
            wait_ack(base + k);
            ret();
         end
         $display("test polling round %0d done", r);
      end
      close_out();
   end
endmodule
`default_nettype wire
